//--- verilog/exception_wake_priority_map.sv
/*
 * Exception and peripheral interrupt arbiter with low-power wake gating.
 * Holds pending state for system exceptions and the seventeen implemented of twenty peripheral lines,
 * picks the most urgent one for the core, and wakes from sleep modes.
 * Assumes the core acknowledges the offered number with exc_ack_in and
 * reports the rank of the running handler on active_rank_in.
 */
`timescale 1ns/1ps
module exception_wake_priority_map (
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	input  wire logic [19:0] irq_in,
	input  wire logic [19:0] irq_enable_in,
	input  wire logic [59:0] irq_prio_in,
	input  wire logic [47:0] exc_prio_in,
	input  wire logic        mem_fault_in,
	input  wire logic        bus_fault_in,
	input  wire logic        usage_fault_in,
	input  wire logic        mem_fault_en_in,
	input  wire logic        bus_fault_en_in,
	input  wire logic        usage_fault_en_in,
	input  wire logic        svc_in,
	input  wire logic        debug_event_in,
	input  wire logic        pendsrv_set_in,
	input  wire logic        tick_enable_in,
	input  wire logic [23:0] tick_reload_in,
	input  wire logic        exc_ack_in,
	input  wire logic        handler_active_in,
	input  wire logic [3:0]  active_rank_in,
	input  wire logic        sleep_req_in,
	input  wire logic [1:0]  sleep_mode_in,
	output logic             exc_req_out,
	output logic [5:0]       exc_num_out,
	output logic [3:0]       exc_rank_out,
	output logic             nmi_out,
	output logic             escalated_out,
	output logic [35:0]      pending_out,
	output logic [1:0]       power_mode_out,
	output logic             wake_out
);

	localparam int NS = exc_map_pkg::NUM_SLOTS;
	localparam int NI = exc_map_pkg::NUM_IRQ;
	localparam int IB = exc_map_pkg::IRQ_BASE;
	localparam int PW = exc_map_pkg::PRIO_W;

	// ------------------------------------------------------------
	// Rank helper
	// ------------------------------------------------------------
	function automatic logic [3:0] prog_rank(input logic [2:0] p);
		return exc_map_pkg::RANK_PROG + {1'b0, p};
	endfunction

	// Shared by the offer and the wake: a running handler yields only
	// to a strictly more urgent rank
	function automatic logic may_preempt(input logic [3:0] rank,
		input logic busy, input logic [3:0] cur);
		return !busy || rank < cur;
	endfunction

	// ------------------------------------------------------------
	// Tick source
	// ------------------------------------------------------------
	// Expiry pends the tick slot one cycle later, like any other source
	logic tick_expire;

	system_tick_timer #(
		.TICK_W (exc_map_pkg::TICK_W)
	) u_tick (
		.mclk_in    (mclk_in),
		.rst_in     (rst_in),
		.enable_in  (tick_enable_in),
		.reload_in  (tick_reload_in),
		.expire_out (tick_expire)
	);

	// ------------------------------------------------------------
	// Pending state
	// ------------------------------------------------------------
	logic [NS-1:0] pend_q;
	logic [NS-1:0] pend_d;
	logic [NS-1:0] set_v;
	logic [NS-1:0] clr_v;
	logic [NS-1:0] cand;
	logic [NS-1:0] impl_mask;
	logic          escal;
	logic          escal_q;
	logic          escal_d;
	logic          exc_req_q;
	logic [5:0]    exc_num_q;

	assign impl_mask = {exc_map_pkg::IRQ_IMPL_MASK,
		exc_map_pkg::SYS_IMPL_MASK};

	always_comb begin
		set_v = '0;
		clr_v = '0;
		// Fault with its own handler off goes to the hard fault
		escal = (mem_fault_in & ~mem_fault_en_in)
			| (bus_fault_in & ~bus_fault_en_in)
			| (usage_fault_in & ~usage_fault_en_in);
		set_v[exc_map_pkg::EXC_HARD] = escal;
		set_v[exc_map_pkg::EXC_NMI] = 1'b0;
		set_v[exc_map_pkg::EXC_MEM] = mem_fault_in
			& mem_fault_en_in;
		set_v[exc_map_pkg::EXC_BUS] = bus_fault_in
			& bus_fault_en_in;
		set_v[exc_map_pkg::EXC_USAGE] = usage_fault_in
			& usage_fault_en_in;
		set_v[exc_map_pkg::EXC_SVC] = svc_in;
		set_v[exc_map_pkg::EXC_DEBUG] = debug_event_in;
		set_v[exc_map_pkg::EXC_PENDSRV] = pendsrv_set_in;
		set_v[exc_map_pkg::EXC_TICK] = tick_expire;
		// Line p lands at slot 16+p only when accepted by the enable
		set_v[IB +: NI] = irq_in & irq_enable_in;
		if (exc_req_q && exc_ack_in) begin
			clr_v[exc_num_q] = 1'b1;
		end
		// Set wins over the acknowledge clear in the same cycle
		pend_d = ((pend_q & ~clr_v) | set_v) & impl_mask;
		cand = pend_q & ~clr_v & impl_mask;
		escal_d = escal;
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			// Reset is offered first, before any other slot
			pend_q  <= exc_map_pkg::PEND_RESET;
			escal_q <= 1'b0;
		end else begin
			pend_q  <= pend_d;
			escal_q <= escal_d;
		end
	end

	// ------------------------------------------------------------
	// Arbitration
	// ------------------------------------------------------------
	logic [3:0] slot_rank [NS];
	logic [5:0] best_num;
	logic [3:0] best_rank;
	logic [3:0] light_rank;
	logic [3:0] deep_rank;

	always_comb begin
		for (int k = 0; k < NS; k++) begin
			if (k == 1) begin
				slot_rank[k] = exc_map_pkg::RANK_RESET;
			end else if (k == 2) begin
				slot_rank[k] = exc_map_pkg::RANK_NMI;
			end else if (k == 3) begin
				slot_rank[k] = exc_map_pkg::RANK_HARD;
			end else if (k < IB) begin
				slot_rank[k] = prog_rank(exc_prio_in[k*PW +: PW]);
			end else begin
				slot_rank[k] = prog_rank(
					irq_prio_in[(k-IB)*PW +: PW]);
			end
		end
	end

	always_comb begin
		best_num   = '0;
		best_rank  = exc_map_pkg::RANK_NONE;
		light_rank = exc_map_pkg::RANK_NONE;
		deep_rank  = exc_map_pkg::RANK_NONE;
		// Ascending scan with strict compare keeps the lower number
		for (int k = 1; k < NS; k++) begin
			if (cand[k] && slot_rank[k] < best_rank) begin
				best_num  = 6'(k);
				best_rank = slot_rank[k];
			end
		end
		for (int p = 0; p < NI; p++) begin
			if (cand[IB+p] && slot_rank[IB+p] < light_rank) begin
				light_rank = slot_rank[IB+p];
			end
			if (cand[IB+p] && exc_map_pkg::DEEP_WAKE_MASK[p]
				&& slot_rank[IB+p] < deep_rank) begin
				deep_rank = slot_rank[IB+p];
			end
		end
	end

	// ------------------------------------------------------------
	// Offer to the core
	// ------------------------------------------------------------
	// Registered offer: a take at one edge shows the next pick from that
	// same edge, so the core may take back to back
	logic       exc_req_d;
	logic [5:0] exc_num_d;
	logic [3:0] exc_rank_q;
	logic [3:0] exc_rank_d;

	exc_map_pkg::power_mode_e mode_q;
	exc_map_pkg::power_mode_e mode_d;

	always_comb begin
		// A running handler is only preempted by a more urgent slot,
		// and nothing is offered to a sleeping core
		exc_req_d = (best_rank != exc_map_pkg::RANK_NONE)
			&& may_preempt(best_rank, handler_active_in,
			active_rank_in)
			&& (mode_q == exc_map_pkg::MODE_ACTIVE);
		exc_num_d  = best_num;
		exc_rank_d = best_rank;
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			exc_req_q  <= 1'b0;
			exc_num_q  <= 6'h00;
			exc_rank_q <= exc_map_pkg::RANK_NONE;
		end else begin
			exc_req_q  <= exc_req_d;
			exc_num_q  <= exc_num_d;
			exc_rank_q <= exc_rank_d;
		end
	end

	// ------------------------------------------------------------
	// Power mode and wake
	// ------------------------------------------------------------
	logic wake_light;
	logic wake_deep;
	logic wake_q;
	logic wake_d;

	always_comb begin
		// Only peripheral lines wake the core; system exceptions wait
		wake_light = (light_rank != exc_map_pkg::RANK_NONE)
			&& may_preempt(light_rank, handler_active_in,
			active_rank_in);
		wake_deep = (deep_rank != exc_map_pkg::RANK_NONE)
			&& may_preempt(deep_rank, handler_active_in,
			active_rank_in);
		mode_d = mode_q;
		wake_d = 1'b0;
		unique case (mode_q)
			exc_map_pkg::MODE_ACTIVE: begin
				// A request for mode zero leaves the mode as it is
				if (sleep_req_in) begin
					mode_d = exc_map_pkg::power_mode_e'(sleep_mode_in);
				end
			end
			exc_map_pkg::MODE_LIGHT: begin
				if (wake_light) begin
					mode_d = exc_map_pkg::MODE_ACTIVE;
					wake_d = 1'b1;
				end
			end
			exc_map_pkg::MODE_DEEP2,
			exc_map_pkg::MODE_DEEP3: begin
				if (wake_deep) begin
					mode_d = exc_map_pkg::MODE_ACTIVE;
					wake_d = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			mode_q <= exc_map_pkg::MODE_ACTIVE;
			wake_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			wake_q <= wake_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign exc_req_out    = exc_req_q;
	assign exc_num_out    = exc_num_q;
	assign exc_rank_out   = exc_rank_q;
	// No source is wired to the nonmaskable slot
	assign nmi_out        = 1'b0;
	assign escalated_out  = escal_q;
	assign pending_out    = pend_q;
	assign power_mode_out = mode_q;
	assign wake_out       = wake_q;

endmodule

//--- verilog/exc_map_pkg.sv
/*
 * Constants for the exception and wake priority map: exception numbers,
 * slot masks, priority ranks and power modes.
 * Assumes a single system clock and a synchronous reset.
 */
package exc_map_pkg;

	// ------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------
	localparam int PRIO_W     = 3;
	localparam int RANK_W     = 4;
	localparam int EXC_W      = 6;
	localparam int NUM_IRQ    = 20;
	localparam int IRQ_BASE   = 16;
	localparam int NUM_SLOTS  = IRQ_BASE + NUM_IRQ;
	localparam int TICK_W     = 24;

	// ------------------------------------------------------------
	// Exception numbers
	// ------------------------------------------------------------
	localparam logic [5:0] EXC_RESET   = 6'h01;
	localparam logic [5:0] EXC_NMI     = 6'h02;
	localparam logic [5:0] EXC_HARD    = 6'h03;
	localparam logic [5:0] EXC_MEM     = 6'h04;
	localparam logic [5:0] EXC_BUS     = 6'h05;
	localparam logic [5:0] EXC_USAGE   = 6'h06;
	localparam logic [5:0] EXC_SVC     = 6'h0B;
	localparam logic [5:0] EXC_DEBUG   = 6'h0C;
	localparam logic [5:0] EXC_PENDSRV = 6'h0E;
	localparam logic [5:0] EXC_TICK    = 6'h0F;

	// ------------------------------------------------------------
	// Slot masks: implemented lines, deep-sleep wake lines
	// ------------------------------------------------------------
	localparam logic [19:0] IRQ_IMPL_MASK  = 20'hF_A7FF;
	localparam logic [19:0] DEEP_WAKE_MASK = 20'h0_07FF;
	localparam logic [15:0] SYS_IMPL_MASK  = 16'hD87A;
	localparam logic [35:0] PEND_RESET     = 36'h0_0000_0002;

	// ------------------------------------------------------------
	// Ranks: lower value is the more urgent
	// ------------------------------------------------------------
	localparam logic [3:0] RANK_RESET = 4'h0;
	localparam logic [3:0] RANK_NMI   = 4'h1;
	localparam logic [3:0] RANK_HARD  = 4'h2;
	localparam logic [3:0] RANK_PROG  = 4'h3;
	localparam logic [3:0] RANK_NONE  = 4'hF;

	localparam logic [23:0] TICK_RESET = 24'h00_0000;

	typedef enum logic [1:0] {
		MODE_ACTIVE = 2'b00,
		MODE_LIGHT  = 2'b01,
		MODE_DEEP2  = 2'b10,
		MODE_DEEP3  = 2'b11
	} power_mode_e;

endpackage

//--- verilog/system_tick_timer.sv
/*
 * System tick countdown: reloads and pulses once per expiry.
 * Assumes reload and enable are held steady by the surrounding logic.
 */
`timescale 1ns/1ps
module system_tick_timer #(
	parameter int TICK_W = exc_map_pkg::TICK_W
) (
	input  wire logic              mclk_in,
	input  wire logic              rst_in,
	input  wire logic              enable_in,
	input  wire logic [TICK_W-1:0] reload_in,
	output logic                   expire_out
);

	logic [TICK_W-1:0] count_q;
	logic [TICK_W-1:0] count_d;
	logic              expire_q;
	logic              expire_d;

	// ------------------------------------------------------------
	// Countdown
	// ------------------------------------------------------------
	always_comb begin
		count_d  = count_q;
		expire_d = 1'b0;
		if (!enable_in) begin
			count_d = reload_in;
		end else if (count_q == '0) begin
			count_d = reload_in;
		end else begin
			count_d = count_q - 1'b1;
			// Period is reload plus one cycles
			expire_d = (count_q == TICK_W'(1));
		end
	end

	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			count_q  <= exc_map_pkg::TICK_RESET[TICK_W-1:0];
			expire_q <= 1'b0;
		end else begin
			count_q  <= count_d;
			expire_q <= expire_d;
		end
	end

	assign expire_out = expire_q;

endmodule

//--- test/exc_map_asserts.sv
/* Port checker for the exception and wake map, bound to its top module.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module exc_map_checker (
	input wire logic        mclk_in,
	input wire logic        rst_in,
	input wire logic        mem_fault_in,
	input wire logic        mem_fault_en_in,
	input wire logic        svc_in,
	input wire logic        handler_active_in,
	input wire logic [3:0]  active_rank_in,
	input wire logic        exc_req_out,
	input wire logic [5:0]  exc_num_out,
	input wire logic [3:0]  exc_rank_out,
	input wire logic        nmi_out,
	input wire logic        escalated_out,
	input wire logic [35:0] pending_out,
	input wire logic [1:0]  power_mode_out,
	input wire logic        wake_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	// ------------------------------------------------------------
	// Sequences and properties
	// ------------------------------------------------------------
	sequence s_rel; $fell(rst_in); endsequence
	sequence s_deep_wake; power_mode_out[1] ##1 wake_out; endsequence
	property p_reset; s_rel |-> !exc_req_out && pending_out == 36'h2
		##1 exc_req_out && exc_num_out == 6'h01 && exc_rank_out == 4'h0;
	endproperty
	property p_nmi; !nmi_out && !pending_out[2]; endproperty
	property p_escal;
		mem_fault_in && !mem_fault_en_in |=> escalated_out && pending_out[3];
	endproperty
	property p_mem; mem_fault_in && mem_fault_en_in |=> pending_out[4];
	endproperty
	property p_svc; svc_in |=> pending_out[11]; endproperty
	property p_resv; pending_out[10:7] == 4'h0 && !pending_out[13]
		&& !pending_out[27] && !pending_out[28] && !pending_out[30];
	endproperty
	property p_deep_ret; s_deep_wake |-> power_mode_out == 2'b00; endproperty
	property p_deep_only;
		power_mode_out[1] && pending_out[26:16] == 11'h000 |=> !wake_out;
	endproperty
	property p_light; power_mode_out == 2'b01 && pending_out[35:16] != 20'h0
		&& !handler_active_in |=> wake_out && power_mode_out == 2'b00;
	endproperty
	property p_gate; handler_active_in && active_rank_in <= 4'h3
		&& power_mode_out != 2'b00 |=> !wake_out;
	endproperty
	a_reset: assert property (p_reset) else $error("bad reset offer");
	a_nmi: assert property (p_nmi) else $error("nmi raised");
	a_escal: assert property (p_escal) else $error("no escalation");
	a_mem: assert property (p_mem) else $error("mem fault lost");
	a_svc: assert property (p_svc) else $error("svc lost");
	a_resv: assert property (p_resv) else $error("reserved slot set");
	a_deep_ret: assert property (p_deep_ret) else $error("not active");
	a_deep_only: assert property (p_deep_only) else $error("bad wake");
	a_light: assert property (p_light) else $error("no light wake");
	a_gate: assert property (p_gate) else $error("wake in handler");
endmodule

bind exception_wake_priority_map exc_map_checker chk_u (.mclk_in, .rst_in,
	.mem_fault_in, .mem_fault_en_in, .svc_in, .handler_active_in,
	.active_rank_in, .exc_req_out, .exc_num_out, .exc_rank_out, .nmi_out,
	.escalated_out, .pending_out, .power_mode_out, .wake_out);

//--- test/core_stub.sv
/* Core-side stub: takes each offered exception, promptly or late.
   Assumes offers change only on rising clock edges. */
`timescale 1ns/1ps
module core_stub (
	input  wire logic mclk_in,
	input  wire logic rst_in,
	input  wire logic en_in,
	input  wire logic slow_in,
	input  wire logic req_in,
	output logic      ack_out
);
	int wait_q;
	// Ack only while an offer stands, so no take is ever refused
	always @(negedge mclk_in) begin
		if (rst_in || !en_in || !req_in) begin
			ack_out <= 1'b0;
			wait_q  <= 0;
		end else if (slow_in && wait_q < 3) begin
			ack_out <= 1'b0;
			wait_q  <= wait_q + 1;
		end else begin
			ack_out <= 1'b1;
			wait_q  <= 0;
		end
	end
endmodule

//--- test/tb.sv
/* Self-checking bench for the exception and wake map.
   Assumes the core stub takes offers; inputs change on falling edges. */
`timescale 1ns/1ps
module tb;
	logic        mclk_in, rst_in, exc_ack_in, model_en, slow;
	logic        mem_fault_in, bus_fault_in, usage_fault_in, svc_in;
	logic        mem_fault_en_in, bus_fault_en_in, usage_fault_en_in;
	logic        debug_event_in, pendsrv_set_in, tick_enable_in;
	logic        handler_active_in, sleep_req_in, exc_req_out, nmi_out;
	logic        escalated_out, wake_out;
	logic [19:0] irq_in, irq_enable_in;
	logic [59:0] irq_prio_in;
	logic [47:0] exc_prio_in;
	logic [23:0] tick_reload_in;
	logic [3:0]  active_rank_in, exc_rank_out;
	logic [1:0]  sleep_mode_in, power_mode_out;
	logic [5:0]  exc_num_out;
	logic [35:0] pending_out, exp_q;
	int          seed, miscompares, compares, cyc;
	time         last_tick;
	// Mode, handler, active rank, line
	logic [19:0] rows [8] = '{20'h2_000F, 20'h2_0003, 20'h3_000A, 20'h3_000D,
		20'h1_000F, 20'h1_1405, 20'h3_1401, 20'h1_1301};

	exception_wake_priority_map dut_u (.mclk_in, .rst_in, .irq_in,
		.irq_enable_in, .irq_prio_in, .exc_prio_in, .mem_fault_in,
		.bus_fault_in, .usage_fault_in, .mem_fault_en_in, .bus_fault_en_in,
		.usage_fault_en_in, .svc_in, .debug_event_in, .pendsrv_set_in,
		.tick_enable_in, .tick_reload_in, .exc_ack_in, .handler_active_in,
		.active_rank_in, .sleep_req_in, .sleep_mode_in, .exc_req_out,
		.exc_num_out, .exc_rank_out, .nmi_out, .escalated_out, .pending_out,
		.power_mode_out, .wake_out);
	core_stub core_u (.mclk_in, .rst_in, .en_in(model_en), .slow_in(slow),
		.req_in(exc_req_out), .ack_out(exc_ack_in));

	// ------------------------------------------------------------
	// Expectations and checks
	// ------------------------------------------------------------
	function automatic logic [3:0] rank_of(input int n);
		if (n < 4) return 4'(n - 1);
		if (n < 16) return 4'h3 + {1'b0, exc_prio_in[3*n +: 3]};
		return 4'h3 + {1'b0, irq_prio_in[3*(n-16) +: 3]};
	endfunction
	function automatic int best(input logic [35:0] m);
		int b;
		b = 0;
		for (int n = 35; n > 0; n--)
			if (m[n] && (b == 0 || rank_of(n) <= rank_of(b))) b = n;
		return b;
	endfunction
	function automatic logic wake_exp(input logic [19:0] r);
		int l;
		l = int'(r[4:0]);
		return exc_map_pkg::IRQ_IMPL_MASK[l] && (r[17:16] == 2'b01 || l <= 10)
			&& (!r[12] || rank_of(l + 16) < r[11:8]);
	endfunction
	task automatic chk(input logic [35:0] got, input logic [35:0] want);
		compares++;
		if (got !== want) begin
			miscompares++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic end_sim;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic pulse(input logic [19:0] m);
		irq_in = m;
		exp_q[35:16] |= m & exc_map_pkg::IRQ_IMPL_MASK;
		@(negedge mclk_in);
		irq_in = '0;
	endtask
	task automatic drain;
		model_en = 1'b1;
		for (int k = 0; k < 200 && exp_q != 0; k++) @(negedge mclk_in);
		repeat (3) @(negedge mclk_in);
		chk(pending_out, 36'h0);
	endtask
	task automatic arb_trial(input logic [31:0] r);
		model_en = 1'b0;
		slow = r[9];
		exc_prio_in = 48'({$random(seed), $random(seed)});
		irq_prio_in = 60'({$random(seed), $random(seed)});
		{pendsrv_set_in, debug_event_in, svc_in, usage_fault_en_in,
			usage_fault_in, bus_fault_en_in, bus_fault_in, mem_fault_en_in,
			mem_fault_in} = r[8:0];
		exp_q[3] = (r[0] & !r[1]) | (r[2] & !r[3]) | (r[4] & !r[5]);
		exp_q[6:4] = {r[4] & r[5], r[2] & r[3], r[0] & r[1]};
		exp_q[14:11] = {r[8], 1'b0, r[7], r[6]};
		pulse(r[31:12]);
		{pendsrv_set_in, debug_event_in, svc_in, usage_fault_in,
			bus_fault_in, mem_fault_in} = '0;
		repeat (2) @(negedge mclk_in);
		chk(pending_out, exp_q);
		drain();
	endtask
	task automatic sleep_row(input logic [19:0] r);
		logic w;
		w = wake_exp(r);
		handler_active_in = r[12];
		active_rank_in = r[11:8];
		sleep_req_in = 1'b1;
		sleep_mode_in = r[17:16];
		@(negedge mclk_in);
		sleep_req_in = 1'b0;
		pulse(20'h0_0001 << r[4:0]);
		repeat (3) @(negedge mclk_in);
		chk(power_mode_out, w ? 36'h0 : 36'(r[17:16]));
		handler_active_in = 1'b0;
		pulse(20'h0_0002);
		drain();
	endtask

	// ------------------------------------------------------------
	// Clock, take monitor, timeout, main sequence
	// ------------------------------------------------------------
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			end_sim();
		end else if (!rst_in && exc_req_out === 1'b1
			&& exc_ack_in === 1'b1) begin
			if (exc_num_out === 6'h0F) begin
				if (last_tick != 0)
					chk(36'($time - last_tick), 36'h78);
				last_tick = $time;
			end else begin
				chk(36'(exc_num_out), 36'(best(exp_q)));
				chk(36'(exc_rank_out), 36'(rank_of(best(exp_q))));
				exp_q[exc_num_out] = 1'b0;
			end
		end
	end
	initial begin
		seed = 32'h0915_379E;
		{miscompares, compares, cyc, last_tick} = '0;
		{model_en, slow, irq_in, irq_prio_in, exc_prio_in, tick_reload_in} = '0;
		{mem_fault_in, bus_fault_in, usage_fault_in, svc_in, debug_event_in,
			pendsrv_set_in, tick_enable_in, handler_active_in} = '0;
		{mem_fault_en_in, bus_fault_en_in, usage_fault_en_in} = '0;
		{sleep_req_in, sleep_mode_in, active_rank_in} = '0;
		irq_enable_in = 20'hF_FFFF;
		exp_q = 36'h0_0000_0002;
		rst_in = 1'b1;
		repeat (2) @(negedge mclk_in);
		rst_in = 1'b0;
		drain();
		$display("reset offer done");
		arb_trial(32'hFFFF_FFFF);
		arb_trial(32'hFFFF_F0D5);
		repeat (30) arb_trial($random(seed));
		$display("arbitration trials done");
		irq_prio_in = 60'h000_0000_0001_0000;
		foreach (rows[i]) sleep_row(rows[i]);
		$display("sleep rows done");
		slow = 1'b0;
		tick_reload_in = 24'h00_0005;
		tick_enable_in = 1'b1;
		repeat (40) @(negedge mclk_in);
		tick_enable_in = 1'b0;
		chk(36'(last_tick != 0), 36'h1);
		$display("tick test done");
		end_sim();
	end
endmodule
